// ===== core/ctm_pkg.sv
// Package of constants and types for the compact timer mode/output block
// Function
// - Mode field: 00 compare output, 01 undefined, 10 PWM, 11 timer.
// - Compare mode A match: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM pin action: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - Requested level equal to the current level gives no visible change.
// - Compare mode level bit sets pin start level, restored on on-bit rise.
// - PWM level bit picks active level; no effect in timer mode.
// - Invert bit inverts pin; no effect in timer mode.
// - Swap bit 0: P period, A duty; 1: roles exchanged.
// - Clear select 1 clears on A; 0 clears on P or overflow.
// - PWM ignores clear select; the period comparator clears the counter.
// - Compare mode, clear select low: both A and P flags raised.
// - Clear select high outside PWM: only the A flag, never the P flag.
// - Clear select high, A zero: overflow at 3FF, no A flag.
// - Compare mode pin changes only on an A match or an on-bit rise.
// - Timer mode counts and flags like compare mode but leaves the pin.
// - PWM mode raises separate A and P match flags.
// - PWM counting continues while the pin is forced to a level.
// - PWM with swap 0: P match clears counter, starting a period.
// - P field matches counter bits 9..7; 000 is 1024, 001 is 128.
// - On-bit rise zeroes the counter; fall stops and keeps the count.
// - Duty at or above period keeps the PWM output active all period.
package ctm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned AW       = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_MODE = 8'h04;
  localparam logic [7:0]  OFS_CMPA = 8'h08;
  localparam logic [7:0]  OFS_CNT  = 8'h0C;
  localparam logic [7:0]  OFS_FLAG = 8'h10;

  // Control word: on bit and P field
  localparam int unsigned CTRL_ON  = 3;
  localparam int unsigned CTRL_P   = 0;
  // Mode register fields
  localparam int unsigned MD_MODE  = 6;
  localparam int unsigned MD_IO    = 4;
  localparam int unsigned MD_OC    = 3;
  localparam int unsigned MD_POL   = 2;
  localparam int unsigned MD_DPX   = 1;
  localparam int unsigned MD_CCLR  = 0;
  // Flag register fields
  localparam int unsigned FL_A     = 0;
  localparam int unsigned FL_P     = 1;
  localparam int unsigned FL_LVL   = 2;

  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [1:0]  RESP_OK  = 2'b00;
  localparam logic [1:0]  RESP_ERR = 2'b10;

  // ---------------------------------------------------------------
  // Counter constants
  // ---------------------------------------------------------------
  localparam logic [9:0]  CNT_ONE  = 10'h001;
  localparam logic [10:0] FULL_PER = 11'h400;

  // Pin action codes
  localparam logic [1:0]  IO_00    = 2'b00;
  localparam logic [1:0]  IO_01    = 2'b01;
  localparam logic [1:0]  IO_10    = 2'b10;
  localparam logic [1:0]  IO_11    = 2'b11;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_UND = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } ctm_mode_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic          awvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          bready;
    logic [AW-1:0] araddr;
    logic          arvalid;
    logic          rready;
  } ctm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ctm_axi_rsp_t;

  typedef struct packed {
    logic          on;
    logic          on_prev;
    logic [2:0]    pfield;
    logic [7:0]    mode;
    logic [9:0]    cmpa;
    logic [9:0]    cnt;
    logic          lvl;
    logic          flag_a;
    logic          flag_p;
    logic          awhave;
    logic          whave;
    logic [AW-1:0] awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    ctm_axi_rsp_t  rsp;
    logic          pin;
    logic          oe_n;
  } ctm_state_t;

  localparam ctm_state_t ST_RST = '{mode: MODE_RST, oe_n: 1'b1, default: '0};

endpackage : ctm_pkg

// ===== core/ctm_core.sv
// Compact timer mode, output control and compare logic with AXI4-Lite slave
module ctm_core
  import ctm_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         count_tick_i,
  input  wire ctm_axi_req_t axi_req_i,
  output ctm_axi_rsp_t      axi_rsp_o,
  output logic              timer_output_pin_o,
  output logic              timer_output_pin_oe_n_o,
  output logic              compare_a_match_flag_o,
  output logic              compare_p_match_flag_o
);

  ctm_state_t s;
  ctm_state_t n;

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  ctm_mode_t   mode;
  logic [1:0]  pin_action_hi_lo;
  logic        initial_or_active_level;
  logic        output_invert;
  logic        period_duty_swap;
  logic        clear_source_select;
  logic        on_rise;
  logic        adv;
  logic [9:0]  nxt;
  logic        a_hit;
  logic        p_hit;
  logic        clr;
  logic        a_set;
  logic        p_set;
  logic [10:0] duty;
  logic        pwm_lvl;

  assign mode                    = ctm_mode_t'(s.mode[MD_MODE +: 2]);
  assign pin_action_hi_lo        = s.mode[MD_IO +: 2];
  assign initial_or_active_level = s.mode[MD_OC];
  assign output_invert           = s.mode[MD_POL];
  assign period_duty_swap        = s.mode[MD_DPX];
  assign clear_source_select     = s.mode[MD_CCLR];

  // ---------------------------------------------------------------
  // Counter and comparators
  // ---------------------------------------------------------------
  assign on_rise = s.on & ~s.on_prev;
  assign adv     = s.on & ~on_rise & count_tick_i;
  assign nxt     = s.cnt + CNT_ONE;
  // A of zero never matches, so a clear on A falls back to the wrap
  assign a_hit   = adv & (s.cmpa != '0) & (nxt == s.cmpa);
  // Upper three bits against P with the lower seven bits zero; P of zero matches at the wrap to zero
  assign p_hit   = adv & (nxt[9:7] == s.pfield) & (nxt[6:0] == '0);

  always_comb begin
    if (mode == MODE_PWM) begin
      clr = period_duty_swap ? a_hit : p_hit;
    end else begin
      clr = clear_source_select ? a_hit : p_hit;
    end
  end

  assign a_set = a_hit;
  // P flag suppressed when A clears the counter outside PWM
  assign p_set = p_hit & ((mode == MODE_PWM) | ~clear_source_select);

  // Duty from the non-period comparator; P of zero counts as 1024
  always_comb begin
    if (period_duty_swap) begin
      duty = (s.pfield == '0) ? FULL_PER : {1'b0, s.pfield, 7'h00};
    end else begin
      duty = {1'b0, s.cmpa};
    end
  end

  // Count never reaches the period, so duty >= period stays active
  assign pwm_lvl = ({1'b0, s.cnt} < duty) ? initial_or_active_level
                                          : ~initial_or_active_level;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    n.on_prev = s.on;

    // Write channel
    if (s.rsp.bvalid && axi_req_i.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (axi_req_i.awvalid && s.rsp.awready) begin
      n.awhave = 1'b1;
      n.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s.rsp.wready) begin
      n.whave = 1'b1;
      n.wdata = axi_req_i.wdata;
      n.wstrb = axi_req_i.wstrb;
    end
    if (n.awhave && n.whave && !n.rsp.bvalid) begin
      n.awhave     = 1'b0;
      n.whave      = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_OK;
      case (n.awaddr)
        OFS_CTRL: begin
          if (n.wstrb[0]) begin
            n.on     = n.wdata[CTRL_ON];
            n.pfield = n.wdata[CTRL_P +: 3];
          end
        end
        OFS_MODE: begin
          if (n.wstrb[0]) begin
            n.mode = n.wdata[7:0];
          end
        end
        OFS_CMPA: begin
          if (n.wstrb[0]) begin
            n.cmpa[7:0] = n.wdata[7:0];
          end
          if (n.wstrb[1]) begin
            n.cmpa[9:8] = n.wdata[9:8];
          end
        end
        OFS_CNT: begin
          // Count is read only; writes are accepted and dropped
        end
        OFS_FLAG: begin
          if (n.wstrb[0] && n.wdata[FL_A]) begin
            n.flag_a = 1'b0;
          end
          if (n.wstrb[0] && n.wdata[FL_P]) begin
            n.flag_p = 1'b0;
          end
        end
        default: n.rsp.bresp = RESP_ERR;
      endcase
    end
    n.rsp.awready = ~n.awhave & ~n.rsp.bvalid;
    n.rsp.wready  = ~n.whave & ~n.rsp.bvalid;

    // Read channel
    if (s.rsp.rvalid && axi_req_i.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && s.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = RESP_OK;
      case (axi_req_i.araddr)
        OFS_CTRL: n.rsp.rdata = {28'h0000_000, s.on, s.pfield};
        OFS_MODE: n.rsp.rdata = {24'h00_0000, s.mode};
        OFS_CMPA: n.rsp.rdata = {22'h00_0000, s.cmpa};
        OFS_CNT:  n.rsp.rdata = {22'h00_0000, s.cnt};
        OFS_FLAG: n.rsp.rdata = {29'h0000_0000, s.lvl, s.flag_p, s.flag_a};
        default: begin
          n.rsp.rdata = '0;
          n.rsp.rresp = RESP_ERR;
        end
      endcase
    end
    n.rsp.arready = ~n.rsp.rvalid;

    // Counter; a fall of the on bit simply stops adv, count is kept
    if (on_rise) begin
      n.cnt = '0;
      if (mode == MODE_CMP) begin
        n.lvl = initial_or_active_level;
      end
    end else if (adv) begin
      n.cnt = clr ? '0 : nxt;
      // Only A moves the level; same level requested shows no change
      if (a_hit && mode == MODE_CMP) begin
        case (pin_action_hi_lo)
          IO_00:   n.lvl = s.lvl;
          IO_01:   n.lvl = 1'b0;
          IO_10:   n.lvl = 1'b1;
          IO_11:   n.lvl = ~s.lvl;
          default: n.lvl = s.lvl;
        endcase
      end
    end

    // Set wins over a software clear in the same cycle
    if (a_set) begin
      n.flag_a = 1'b1;
    end
    if (p_set) begin
      n.flag_p = 1'b1;
    end

    // Pin drive, registered from current state
    case (mode)
      MODE_CMP: begin
        n.pin  = s.lvl ^ output_invert;
        n.oe_n = 1'b0;
      end
      MODE_PWM: begin
        case (pin_action_hi_lo)
          IO_01:   n.pin = initial_or_active_level ^ output_invert;
          IO_10:   n.pin = pwm_lvl ^ output_invert;
          default: n.pin = ~initial_or_active_level ^ output_invert;
        endcase
        n.oe_n = 1'b0;
      end
      default: begin
        // Timer and undefined modes release the pin
        n.pin  = 1'b0;
        n.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign axi_rsp_o               = s.rsp;
  assign timer_output_pin_o      = s.pin;
  assign timer_output_pin_oe_n_o = s.oe_n;
  assign compare_a_match_flag_o  = s.flag_a;
  assign compare_p_match_flag_o  = s.flag_p;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_tmr_release;
    @(posedge clk_i) disable iff (!rst_n_i)
      mode == MODE_TMR |=> timer_output_pin_oe_n_o && !timer_output_pin_o;
  endproperty
  a_tmr_release: assert property (p_tmr_release)
    else $error("timer mode drives the pin");

  property p_rise_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      on_rise && mode == MODE_CMP |=> s.cnt == '0 &&
        s.lvl == $past(initial_or_active_level);
  endproperty
  a_rise_clear: assert property (p_rise_clear)
    else $error("on rise did not restore count and level");

  property p_off_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !s.on ##1 !s.on |-> $stable(s.cnt);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved while off");

  property p_set_high;
    @(posedge clk_i) disable iff (!rst_n_i)
      a_hit && mode == MODE_CMP && pin_action_hi_lo == IO_10
      |=> s.lvl ##1 timer_output_pin_o == (1'b1 ^ $past(output_invert));
  endproperty
  a_set_high: assert property (p_set_high)
    else $error("A match did not drive the pin high");

  property p_p_no_pin;
    @(posedge clk_i) disable iff (!rst_n_i)
      p_hit && !a_hit && mode == MODE_CMP |=> $stable(s.lvl);
  endproperty
  a_p_no_pin: assert property (p_p_no_pin)
    else $error("P match moved the pin level");

  property p_no_pflag;
    @(posedge clk_i) disable iff (!rst_n_i)
      clear_source_select && mode != MODE_PWM && !compare_p_match_flag_o
      |=> !compare_p_match_flag_o;
  endproperty
  a_no_pflag: assert property (p_no_pflag)
    else $error("P flag raised with A clearing");

  property p_a0_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
      adv && s.cmpa == '0 && s.cnt == 10'h3FF |-> !a_set ##1 s.cnt == '0;
  endproperty
  a_a0_wrap: assert property (p_a0_wrap)
    else $error("A of zero flagged or failed to wrap");

  property p_pwm_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      mode == MODE_PWM && !period_duty_swap && p_hit |=> s.cnt == '0;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear)
    else $error("P match did not start a new period");

  property p_flag_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      a_set |=> compare_a_match_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("A flag lost");

  property p_pwm_full;
    @(posedge clk_i) disable iff (!rst_n_i)
      s.on && !on_rise && mode == MODE_PWM && !period_duty_swap
      && s.pfield == 3'b001 && s.cmpa >= 10'h080
      |-> pwm_lvl == initial_or_active_level;
  endproperty
  a_pwm_full: assert property (p_pwm_full)
    else $error("full duty fell inactive");

  c_toggle: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    a_hit && mode == MODE_CMP && pin_action_hi_lo == IO_11);
  c_pwm_period: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == MODE_PWM && clr);
  c_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    adv && s.cnt == 10'h3FF);
  c_a_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    a_hit && clear_source_select && mode != MODE_PWM);

  property p_pflag_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      p_set |=> compare_p_match_flag_o;
  endproperty
  a_pflag_set: assert property (p_pflag_set)
    else $error("P flag lost");

  property p_on_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      on_rise |=> s.cnt == '0;
  endproperty
  a_on_zero: assert property (p_on_zero)
    else $error("on rise did not zero the count");

  property p_a_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      a_hit && clear_source_select && mode != MODE_PWM |=> s.cnt == '0;
  endproperty
  a_a_clear: assert property (p_a_clear)
    else $error("A match did not clear the count");

  property p_pwm_force;
    @(posedge clk_i) disable iff (!rst_n_i)
      mode == MODE_PWM && pin_action_hi_lo == IO_01 |=> timer_output_pin_o
        == ($past(initial_or_active_level) ^ $past(output_invert));
  endproperty
  a_pwm_force: assert property (p_pwm_force)
    else $error("forced active level not on the pin");

endmodule : ctm_core

// ===== tb/ctm_load.sv
// External load model on the timer output pin
module ctm_load (
  input  wire logic  clk_i,
  input  wire logic  pin_i,
  input  wire logic  oe_n_i,
  input  wire logic  clr_i,
  output logic       line_o,
  output logic [15:0] high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds the line high once the pin is released
  assign line_o = oe_n_i ? 1'b1 : pin_i;
  // Counts high cycles so the bench can judge duty over a window
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      high_o <= 16'h0000;
    end else if (line_o) begin
      high_o <= high_o + 16'h0001;
    end
  end
endmodule : ctm_load

// ===== tb/testbench.sv
// Self-checking bench for the compact timer mode and output block
module testbench
  import ctm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rst_n, tick, clr, pin, oe_n, fa, fp, line;
  logic [15:0]  high;
  ctm_axi_req_t req;
  ctm_axi_rsp_t rsp;
  int           n_mismatch, checked;
  logic [31:0]  d;
  logic [1:0]   r;

  ctm_core ctm_core_i (.clk_i(clk), .rst_n_i(rst_n), .count_tick_i(tick),
    .axi_req_i(req), .axi_rsp_o(rsp), .timer_output_pin_o(pin),
    .timer_output_pin_oe_n_o(oe_n), .compare_a_match_flag_o(fa),
    .compare_p_match_flag_o(fp));
  ctm_load ctm_load_i (.clk_i(clk), .pin_i(pin), .oe_n_i(oe_n),
    .clr_i(clr), .line_o(line), .high_o(high));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task stop_test();
    $display("counts: %0d checked, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string msg);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task timeout(input string msg);
    n_mismatch++;
    $display("wrong value at %0t: wait ran out in %s", $time, msg);
    stop_test();
  endtask : timeout

  // ---------------------------------------------------------------
  // AXI4-Lite master
  // ---------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n == 50) timeout("write");
  endtask : wr

  task rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 50) timeout("read");
  endtask : rd

  task w(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    check(r, RESP_OK, "write response");
  endtask : w

  task idle(input int c);
    repeat (c) @(posedge clk);
  endtask : idle

  task wait_flag(input bit p);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if ((p ? fp : fa) === 1'b1) break;
    end
    if (n == 3000) timeout("flag");
  endtask : wait_flag

  // Stops the timer before any setup change, as software must
  task setup(input logic [7:0] md, input logic [9:0] a, input logic [3:0] c);
    @(posedge clk);
    tick <= 1'b0;
    w(OFS_CTRL, 32'h0000_0000);
    w(OFS_MODE, {24'h0, md});
    w(OFS_CMPA, {22'h0, a});
    w(OFS_FLAG, 32'h0000_0003);
    w(OFS_CTRL, {28'h0, c});
  endtask : setup

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs();
    rd(OFS_MODE);
    check(d, {24'h0, MODE_RST}, "mode reset value");
    rd(OFS_CTRL);
    check(d, 32'h0000_0000, "control reset value");
    check(oe_n, 1'b0, "pin driven in reset mode");
    check(line, 1'b0, "initial low level");
    w(OFS_MODE, 32'h0000_00ff);
    rd(OFS_MODE);
    check(d, 32'h0000_00ff, "mode read back");
    rd(8'h14);
    check({r, d[29:0]}, {RESP_ERR, 30'h0}, "unmapped read");
    wr(8'h14, 32'h0000_0001);
    check(r, RESP_ERR, "unmapped write");
    $display("test regs done");
  endtask : t_regs

  task t_cmp();
    logic pol, lvl;
    for (int i = 0; i < 4; i++) begin
      pol = (i == 1);
      lvl = (i == 0 || i == 2);
      setup({2'b00, i[1:0], 1'b1, pol, 2'b00}, 10'h010, 4'h8);
      idle(4);
      check(line, 1'b1 ^ pol, "start level");
      tick <= 1'b1;
      wait_flag(0);
      tick <= 1'b0;
      idle(4);
      check(line, lvl ^ pol, "level after A match");
    end
    $display("test compare done");
  endtask : t_cmp

  task t_flags();
    setup(8'h20, 10'h300, 4'h9);
    tick <= 1'b1;
    wait_flag(1);
    idle(2);
    check(fa, 1'b0, "P clear before far A");
    check(line, 1'b0, "P match leaves pin");
    setup(8'h21, 10'h100, 4'h9);
    rd(OFS_FLAG);
    check(d[1:0], 2'b00, "flags cleared by write");
    tick <= 1'b1;
    wait_flag(0);
    idle(600);
    check(fp, 1'b0, "no P flag with A clear");
    rd(OFS_CNT);
    check(d[9:0] < 10'h100, 1'b1, "count stays below A");
    setup(8'h21, 10'h000, 4'h9);
    tick <= 1'b1;
    idle(1100);
    check(fa, 1'b0, "A zero raises no flag");
    $display("test flags done");
  endtask : t_flags

  task t_timer();
    setup(8'h40, 10'h010, 4'h0);
    check(oe_n, 1'b1, "undefined mode releases pin");
    setup(8'he0, 10'h010, 4'h0);
    check(oe_n, 1'b1, "timer mode releases pin");
    w(OFS_CTRL, 32'h0000_0008);
    tick <= 1'b1;
    wait_flag(0);
    check(line, 1'b1, "released line pulled up");
    $display("test timer done");
  endtask : t_timer

  task pwm_case(input logic [7:0] md, input logic [9:0] a,
                input logic [15:0] exp);
    setup(md, a, 4'h9);
    tick <= 1'b1;
    idle(300);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    idle(256);
    #1;
    check(high, exp, "high cycles over 256");
    check(fp, 1'b1, "P flag in PWM");
  endtask : pwm_case

  task t_pwm();
    pwm_case(8'ha8, 10'h020, 16'h0040);
    pwm_case(8'ha8, 10'h0c8, 16'h0100);
    pwm_case(8'haa, 10'h100, 16'h0080);
    pwm_case(8'ha0, 10'h020, 16'h00c0);
    pwm_case(8'hac, 10'h020, 16'h00c0);
    pwm_case(8'ha9, 10'h020, 16'h0040);
    pwm_case(8'h88, 10'h020, 16'h0000);
    pwm_case(8'h98, 10'h020, 16'h0100);
    $display("test pwm done");
  endtask : t_pwm

  // ---------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #1_000_000;
    timeout("whole run");
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    tick = 1'b0;
    clr = 1'b1;
    req = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    idle(2);
    t_regs();
    t_cmp();
    t_flags();
    t_timer();
    t_pwm();
    stop_test();
  end
endmodule : testbench
